//--- rtl/fpt_pkg.sv
package fpt_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_T12 = 8'hC3;
	localparam logic [7:0] IDX_T34 = 8'hC4;
	localparam logic [7:0] IDX_GPO = 8'hC5;
	localparam logic [7:0] IDX_FORCE = 8'hC6;
	localparam logic [7:0] IDX_MON = 8'hC7;
	localparam logic [7:0] IDX_BIND = 8'hC8;
	localparam logic [7:0] IDX_CTL = 8'hC9;
	localparam logic [7:0] IDX_SPIN = 8'hCA;
	localparam logic [7:0] IDX_AUX = 8'hD8;
	localparam logic [7:0] IDX_STAT = 8'hD9;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 9;
	localparam logic [21:0] ADDR_HI_ZERO = 22'h000000;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [7:0] RST_MON = 8'h11;
	localparam logic [7:0] RST_REG = 8'h00;

	// Field positions
	localparam int B_OVR = 0;
	localparam int B_INV = 1;
	localparam int B_LOCK_EN = 2;
	localparam int B_LOCK = 3;
	localparam int B_MASK1 = 4;
	localparam int B_MASK2 = 5;
	localparam int B_FORCE1 = 6;
	localparam int B_FORCE2 = 7;
	localparam int B_FINE34 = 0;
	localparam int B_SHORT = 1;
	localparam int B_BIND_RAMP = 4;
	localparam int B_SUDUR_MSB = 4;

	// Duty codes: 0 is off, F is continuous
	localparam logic [3:0] DUTY_OFF = 4'h0;
	localparam logic [3:0] DUTY_FULL = 4'hF;
	localparam logic [3:0] MIN_DUTY_TOP = 4'hC;
	localparam logic [3:0] PWM_LAST_PHASE = 4'hE;

	// Timing
	localparam int SYS_CLK_HZ = 100_000_000;
	localparam int THR_CLK_HZ = 22_500;
	localparam int MS_PER_S = 1000;
	localparam int TICK_CYCLES = SYS_CLK_HZ / THR_CLK_HZ;
	localparam int MS_CYCLES = SYS_CLK_HZ / MS_PER_S;
	localparam int SLOT_CYCLES = 260;
	localparam int RAMP_STEP_MS = 50;
	localparam int THR_PERIOD_TICKS = 80;
	localparam int THR_STEP_TICKS = 5;
	localparam logic [18:0] MON_BASE_MS = 19'h002DA;
	localparam logic [3:0] MON_CODE_MAX = 4'h9;

	function automatic logic [14:0] spin_ms(input logic [3:0] code);
		case (code)
			4'h1: spin_ms = 15'h0064;
			4'h2: spin_ms = 15'h00FA;
			4'h3: spin_ms = 15'h0190;
			4'h4: spin_ms = 15'h02BC;
			4'h5: spin_ms = 15'h03E8;
			4'h6: spin_ms = 15'h07D0;
			4'h7: spin_ms = 15'h0FA0;
			4'h8: spin_ms = 15'h1770;
			4'h9: spin_ms = 15'h1F40;
			4'hA: spin_ms = 15'h2710;
			4'hB: spin_ms = 15'h2EE0;
			4'hC: spin_ms = 15'h36B0;
			4'hD: spin_ms = 15'h3E80;
			4'hE: spin_ms = 15'h4650;
			4'hF: spin_ms = 15'h4E20;
			default: spin_ms = 15'h0000;
		endcase
	endfunction : spin_ms
endpackage : fpt_pkg

//--- rtl/fpt_throttle_wave.sv
`timescale 1ns/1ps
module fpt_throttle_wave (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic tick_i,
	input wire logic [3:0] duty_sel_i,
	output logic wave_o
);
	typedef struct packed {
		logic [6:0] cnt;
		logic wave;
	} fpt_wave_type;

	fpt_wave_type st_q;
	fpt_wave_type st_d;
	logic [6:0] limit;

	always_comb begin
		st_d = st_q;
		limit = 7'(fpt_pkg::THR_STEP_TICKS * (int'(duty_sel_i) + 1));
		if (tick_i) begin
			if (st_q.cnt == 7'(fpt_pkg::THR_PERIOD_TICKS - 1)) begin
				st_d.cnt = 7'h00;
			end else begin
				st_d.cnt = st_q.cnt + 7'h01;
			end
		end
		st_d.wave = st_q.cnt < limit;
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign wave_o = st_q.wave;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_period;
		st_q.cnt < 7'(fpt_pkg::THR_PERIOD_TICKS);
	endproperty
	a_period: assert property (p_period)
		else $error("throttle counter beyond period");

	property p_width;
		wave_o |-> $past(st_q.cnt) < 7'(fpt_pkg::THR_STEP_TICKS *
			(int'($past(duty_sel_i)) + 1));
	endproperty
	a_width: assert property (p_width)
		else $error("throttle asserted past its width");
endmodule : fpt_throttle_wave

//--- rtl/fpt_fan_throttle.sv
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
// Function
// - Table pair hysteresis from low nibble
// - Fine bit halves tables three/four resolution
// - Below base temperature request min-duty code
// - Output bit one pulls pin low
// - Mask stops regulator-hot driving throttle
// - Force bit drives throttle waveform
// - Short option drives both throttle outputs
// - Throttle period is eighty slow ticks
// - Asserted five ticks per duty step
// - Monitor interval doubles per code step up to code 9
// - Binding bits attach sources to channel
// - Tables look up, hot sources ramp
// - Largest bound request wins
// - Override field joins as a request
// - Override readback shows duty in use
// - Readback zero during spin-up
// - Inversion bit flips output polarity
// - Lock enable lets throttle set lock
// - Lock holds full duty until cleared
// - Spin-up drives spin duty, zero disables
// - Spin-up on zero to nonzero change
module fpt_fan_throttle #(
	parameter int TICK_CYCLES = fpt_pkg::TICK_CYCLES,
	parameter int MS_CYCLES = fpt_pkg::MS_CYCLES,
	parameter int SLOT_CYCLES = fpt_pkg::SLOT_CYCLES,
	parameter int RAMP_MS = fpt_pkg::RAMP_STEP_MS
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [31:0] table_temp_i,
	input wire logic [31:0] table_base_i,
	input wire logic [15:0] table_step_duty_i,
	input wire logic cpu1_throttle_signal_i,
	input wire logic cpu2_throttle_signal_i,
	input wire logic regulator1_hot_input_i,
	input wire logic regulator2_hot_input_i,
	input wire logic [7:0] gpio_pin_i,
	output logic [7:0] output_pulldown_o,
	output logic [7:0] output_pulldown_oe_o,
	output logic cpu1_throttle_o,
	output logic cpu2_throttle_o,
	output logic fan_pwm_o
);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int MW = $clog2(MS_CYCLES + 1);
	localparam int SW = $clog2(SLOT_CYCLES + 1);
	localparam int RW = $clog2(RAMP_MS + 1);

	typedef struct packed {
		logic [7:0] t12;
		logic [7:0] t34;
		logic [7:0] general_output_pulldown;
		logic [7:0] force_ctl;
		logic [7:0] mon;
		logic [7:0] src_bind;
		logic [7:0] ctl;
		logic [7:0] spin;
		logic [7:0] aux;
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [31:0] rdata;
		logic ready;
		logic [TW-1:0] tick_cnt;
		logic tick;
		logic [MW-1:0] ms_cnt;
		logic ms;
		logic [RW-1:0] ramp_cnt;
		logic [3:0][3:0] ramp;
		logic [3:0] hold;
		logic [SW-1:0] slot_cnt;
		logic [3:0] phase;
		logic lock;
		logic spin_act;
		logic [14:0] spin_cnt;
		logic [3:0] duty;
		logic [3:0] drive;
		logic [1:0][18:0] mon_cnt;
		logic [1:0] mon_seen;
		logic [1:0] mon_flag;
		logic pwm;
		logic thr1;
		logic thr2;
		logic [7:0] pd_oe;
	} fpt_state_type;

	fpt_state_type st_q;
	fpt_state_type st_d;
	logic wave;
	logic acc;
	logic sel;
	logic lock_clr;
	logic lock_ev;
	logic ramp_step;
	logic [3:0] best;
	logic [3:0] req;
	logic [3:0] src_on;
	logic [3:0] spin_code;
	logic [3:0] mon_code;
	logic [8:0] thr;
	logic [31:0] rd;

	function automatic logic [3:0] dmax(input logic [3:0] a,
		input logic [3:0] b);
		dmax = (a > b) ? a : b;
	endfunction : dmax

	// Unmapped codes of the min-duty field fall back to full speed
	function automatic logic [3:0] min_map(input logic [3:0] code);
		min_map = (code > fpt_pkg::MIN_DUTY_TOP) ? fpt_pkg::DUTY_FULL : code;
	endfunction : min_map

	function automatic logic [8:0] hyst_half(input logic [3:0] h,
		input logic fine);
		hyst_half = fine ? {5'h00, h} : {4'h0, h, 1'b0};
	endfunction : hyst_half

	fpt_throttle_wave u_wave (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(st_q.tick),
		.duty_sel_i(st_q.force_ctl[3:0]),
		.wave_o(wave)
	);

	always_comb begin
		rd = 32'h0000_0000;
		case (haddr_i[fpt_pkg::IDX_MSB:fpt_pkg::IDX_LSB])
			fpt_pkg::IDX_T12: rd[7:0] = st_q.t12;
			fpt_pkg::IDX_T34: rd[7:0] = st_q.t34;
			fpt_pkg::IDX_GPO: rd[7:0] = st_q.general_output_pulldown;
			fpt_pkg::IDX_FORCE: rd[7:0] = st_q.force_ctl;
			fpt_pkg::IDX_MON: rd[7:0] = st_q.mon;
			fpt_pkg::IDX_BIND: rd[7:0] = st_q.src_bind;
			fpt_pkg::IDX_CTL: rd[7:0] = {st_q.spin_act ? fpt_pkg::DUTY_OFF :
				st_q.duty, st_q.lock, st_q.ctl[2:0]};
			fpt_pkg::IDX_SPIN: rd[7:0] = st_q.spin;
			fpt_pkg::IDX_AUX: rd[7:0] = st_q.aux;
			fpt_pkg::IDX_STAT: rd[10:0] = {st_q.spin_act, st_q.mon_flag,
				gpio_pin_i};
			default: rd = 32'h0000_0000;
		endcase
	end

	always_comb begin
		st_d = st_q;
		acc = hsel_i && hready_i && htrans_i[1] &&
			hsize_i == fpt_pkg::HSIZE_WORD;
		sel = haddr_i[31:10] == fpt_pkg::ADDR_HI_ZERO;
		lock_clr = 1'b0;
		lock_ev = 1'b0;
		ramp_step = 1'b0;
		best = fpt_pkg::DUTY_OFF;
		req = fpt_pkg::DUTY_OFF;
		thr = 9'h000;
		src_on = {regulator2_hot_input_i, regulator1_hot_input_i,
			cpu2_throttle_signal_i, cpu1_throttle_signal_i};
		spin_code = {st_q.spin[fpt_pkg::B_SUDUR_MSB], st_q.spin[7:5]};
		mon_code = fpt_pkg::DUTY_OFF;

		// Zero wait state slave, always OKAY
		st_d.ready = 1'b1;
		st_d.wr_pend = 1'b0;
		if (acc) begin
			st_d.wr_pend = hwrite_i && sel;
			st_d.wr_idx = haddr_i[fpt_pkg::IDX_MSB:fpt_pkg::IDX_LSB];
			if (!hwrite_i) begin
				st_d.rdata = sel ? rd : 32'h0000_0000;
			end
		end
		if (st_q.wr_pend) begin
			case (st_q.wr_idx)
				fpt_pkg::IDX_T12: st_d.t12 = hwdata_i[7:0];
				fpt_pkg::IDX_T34: st_d.t34 = hwdata_i[7:0];
				fpt_pkg::IDX_GPO: st_d.general_output_pulldown = hwdata_i[7:0];
				fpt_pkg::IDX_FORCE: st_d.force_ctl = hwdata_i[7:0];
				fpt_pkg::IDX_MON: st_d.mon = hwdata_i[7:0];
				fpt_pkg::IDX_BIND: st_d.src_bind = hwdata_i[7:0];
				fpt_pkg::IDX_CTL: begin
					st_d.ctl = {hwdata_i[7:4], 1'b0, hwdata_i[2:0]};
					lock_clr = !hwdata_i[fpt_pkg::B_LOCK];
				end
				fpt_pkg::IDX_SPIN: st_d.spin = hwdata_i[7:0];
				fpt_pkg::IDX_AUX: st_d.aux = {6'h00, hwdata_i[1:0]};
				default: ;
			endcase
		end

		// Timebases: slow throttle tick and millisecond tick
		st_d.tick = st_q.tick_cnt == TW'(TICK_CYCLES - 1);
		st_d.tick_cnt = st_d.tick ? '0 : st_q.tick_cnt + TW'(1);
		st_d.ms = st_q.ms_cnt == MW'(MS_CYCLES - 1);
		st_d.ms_cnt = st_d.ms ? '0 : st_q.ms_cnt + MW'(1);
		if (st_q.ms) begin
			ramp_step = st_q.ramp_cnt == RW'(RAMP_MS - 1);
			st_d.ramp_cnt = ramp_step ? '0 : st_q.ramp_cnt + RW'(1);
		end

		lock_ev = st_q.ctl[fpt_pkg::B_LOCK_EN] &&
			((st_q.src_bind[fpt_pkg::B_BIND_RAMP] &&
			cpu1_throttle_signal_i) ||
			(st_q.src_bind[fpt_pkg::B_BIND_RAMP + 1] &&
			cpu2_throttle_signal_i));
		// Set beats a clearing write in the same cycle
		st_d.lock = lock_ev || (st_q.lock && !lock_clr);

		for (int i = 0; i < 4; i++) begin
			thr = {table_base_i[8*i+7], table_base_i[8*i+:8]} +
				hyst_half(i < 2 ? st_q.t12[3:0] : st_q.t34[3:0],
				i < 2 ? 1'b0 : st_q.aux[fpt_pkg::B_FINE34]);
			if ($signed(table_temp_i[8*i+:8]) <
				$signed(table_base_i[8*i+:8])) begin
				st_d.hold[i] = 1'b1;
			end else if ($signed({table_temp_i[8*i+7],
				table_temp_i[8*i+:8]}) >= $signed(thr)) begin
				st_d.hold[i] = 1'b0;
			end
			req = st_q.hold[i] ? min_map(i < 2 ? st_q.t12[7:4] :
				st_q.t34[7:4]) : table_step_duty_i[4*i+:4];
			if (st_q.src_bind[i]) begin
				best = dmax(best, req);
			end
			// Hot sources ramp up and down
			if (ramp_step) begin
				if (src_on[i] && st_q.ramp[i] != fpt_pkg::DUTY_FULL) begin
					st_d.ramp[i] = st_q.ramp[i] + 4'h1;
				end else if (!src_on[i] && st_q.ramp[i] != fpt_pkg::DUTY_OFF)
					begin
					st_d.ramp[i] = st_q.ramp[i] - 4'h1;
				end
			end
			if (st_q.src_bind[fpt_pkg::B_BIND_RAMP + i]) begin
				best = dmax(best, st_q.ramp[i]);
			end
		end
		if (st_q.ctl[fpt_pkg::B_OVR]) begin
			best = dmax(best, st_q.ctl[7:4]);
		end
		if (st_q.lock) begin
			best = fpt_pkg::DUTY_FULL;
		end
		st_d.duty = best;

		if (st_q.duty == fpt_pkg::DUTY_OFF && best != fpt_pkg::DUTY_OFF &&
			st_q.spin[3:0] != fpt_pkg::DUTY_OFF &&
			fpt_pkg::spin_ms(spin_code) != 15'h0000) begin
			st_d.spin_act = 1'b1;
			st_d.spin_cnt = fpt_pkg::spin_ms(spin_code);
		end else if (st_q.spin_act) begin
			if (best == fpt_pkg::DUTY_OFF || st_q.spin_cnt == 15'h0000) begin
				st_d.spin_act = 1'b0;
			end else if (st_q.ms) begin
				st_d.spin_cnt = st_q.spin_cnt - 15'h0001;
			end
		end
		st_d.drive = st_q.spin_act ? st_q.spin[3:0] : st_q.duty;

		// Fifteen phase slots so code F stays on for the whole period
		st_d.slot_cnt = st_q.slot_cnt + SW'(1);
		if (st_q.slot_cnt == SW'(SLOT_CYCLES - 1)) begin
			st_d.slot_cnt = '0;
			st_d.phase = (st_q.phase == fpt_pkg::PWM_LAST_PHASE) ?
				4'h0 : st_q.phase + 4'h1;
		end
		st_d.pwm = (st_q.phase < st_q.drive) ^ st_q.ctl[fpt_pkg::B_INV];

		for (int c = 0; c < 2; c++) begin
			mon_code = st_q.mon[4*c+:4];
			if (mon_code > fpt_pkg::MON_CODE_MAX) begin
				mon_code = fpt_pkg::MON_CODE_MAX;
			end
			st_d.mon_seen[c] = st_q.mon_seen[c] | src_on[c];
			if (st_q.ms) begin
				if (st_q.mon_cnt[c] == 19'h00000) begin
					st_d.mon_cnt[c] = (fpt_pkg::MON_BASE_MS << mon_code) -
						19'h00001;
					st_d.mon_flag[c] = st_q.mon_seen[c];
					st_d.mon_seen[c] = src_on[c];
				end else begin
					st_d.mon_cnt[c] = st_q.mon_cnt[c] - 19'h00001;
				end
			end
		end

		st_d.thr1 = ((st_q.force_ctl[fpt_pkg::B_FORCE1] ||
			(st_q.aux[fpt_pkg::B_SHORT] &&
			st_q.force_ctl[fpt_pkg::B_FORCE2])) && wave) ||
			(regulator1_hot_input_i && !st_q.force_ctl[fpt_pkg::B_MASK1]);
		st_d.thr2 = ((st_q.force_ctl[fpt_pkg::B_FORCE2] ||
			(st_q.aux[fpt_pkg::B_SHORT] &&
			st_q.force_ctl[fpt_pkg::B_FORCE1])) && wave) ||
			(regulator2_hot_input_i && !st_q.force_ctl[fpt_pkg::B_MASK2]);
		st_d.pd_oe = st_q.general_output_pulldown;
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st_q <= '0;
			st_q.mon <= fpt_pkg::RST_MON;
		end else begin
			st_q <= st_d;
		end
	end

	assign hrdata_o = st_q.rdata;
	assign hreadyout_o = st_q.ready;
	assign hresp_o = st_q.wr_pend & 1'b0;
	assign output_pulldown_o = st_q.pd_oe & fpt_pkg::RST_REG;
	assign output_pulldown_oe_o = st_q.pd_oe;
	assign cpu1_throttle_o = st_q.thr1;
	assign cpu2_throttle_o = st_q.thr2;
	assign fan_pwm_o = st_q.pwm;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_lock_full;
		st_q.lock |=> st_q.duty == fpt_pkg::DUTY_FULL;
	endproperty
	a_lock_full: assert property (p_lock_full)
		else $error("lock did not force full duty");

	property p_lock_off;
		!st_q.ctl[fpt_pkg::B_LOCK_EN] && !st_q.lock |=> !st_q.lock;
	endproperty
	a_lock_off: assert property (p_lock_off)
		else $error("lock set while disabled");

	property p_pulldown;
		1'b1 |=> output_pulldown_oe_o == $past(st_q.general_output_pulldown) &&
			output_pulldown_o == 8'h00;
	endproperty
	a_pulldown: assert property (p_pulldown)
		else $error("pulldown enable mismatch");

	property p_mask;
		st_q.force_ctl[fpt_pkg::B_MASK1] && !wave ##1
			st_q.force_ctl[fpt_pkg::B_MASK1] |-> !cpu1_throttle_o;
	endproperty
	a_mask: assert property (p_mask)
		else $error("masked regulator-hot drove throttle");

	property p_force;
		st_q.force_ctl[fpt_pkg::B_FORCE2] && wave |=> cpu2_throttle_o;
	endproperty
	a_force: assert property (p_force)
		else $error("forced throttle not driven");

	property p_short;
		st_q.aux[fpt_pkg::B_SHORT] && st_q.force_ctl[fpt_pkg::B_FORCE2] &&
			wave |=> cpu1_throttle_o;
	endproperty
	a_short: assert property (p_short)
		else $error("shorted throttle not driven");

	property p_invert;
		st_q.drive == fpt_pkg::DUTY_FULL ##0 st_q.ctl[fpt_pkg::B_INV] |=>
			!fan_pwm_o;
	endproperty
	a_invert: assert property (p_invert)
		else $error("inverted full duty not low");

	property p_spin_read;
		acc && sel && !hwrite_i && st_q.spin_act &&
			haddr_i[fpt_pkg::IDX_MSB:fpt_pkg::IDX_LSB] == fpt_pkg::IDX_CTL
			|=> hrdata_o[7:4] == fpt_pkg::DUTY_OFF;
	endproperty
	a_spin_read: assert property (p_spin_read)
		else $error("duty readback nonzero in spin-up");

	property p_spin_start;
		st_q.duty == fpt_pkg::DUTY_OFF && st_d.duty != fpt_pkg::DUTY_OFF &&
			st_q.spin[3:0] != fpt_pkg::DUTY_OFF && spin_code != 4'h0
			|=> st_q.spin_act ##1 st_q.drive == $past(st_q.spin[3:0]);
	endproperty
	a_spin_start: assert property (p_spin_start)
		else $error("spin-up did not start");

	c_spin: cover property (st_q.spin_act && st_q.drive != 4'h0);
	c_lock: cover property (lock_ev && !st_q.lock);
	c_ovr: cover property (st_q.ctl[fpt_pkg::B_OVR] && st_q.duty != 4'h0);
	c_force: cover property (cpu1_throttle_o && cpu2_throttle_o);
endmodule : fpt_fan_throttle

//--- testbench/fpt_far_side_model.sv
`timescale 1ns/1ps
module fpt_far_side_model (
	input wire logic [7:0] pulldown_oe_i,
	input wire logic [7:0] pin_level_i,
	input wire logic [3:0] hot_req_i,
	output logic [7:0] gpio_pin_o,
	output logic cpu1_throttle_signal_o,
	output logic cpu2_throttle_signal_o,
	output logic regulator1_hot_input_o,
	output logic regulator2_hot_input_o
);
	// External level only on undriven pins
	assign gpio_pin_o = ~pulldown_oe_i & pin_level_i;
	// Processor and regulator hot levels, active high
	assign cpu1_throttle_signal_o = hot_req_i[0];
	assign cpu2_throttle_signal_o = hot_req_i[1];
	assign regulator1_hot_input_o = hot_req_i[2];
	assign regulator2_hot_input_o = hot_req_i[3];
endmodule : fpt_far_side_model

//--- testbench/fan_pwm_throttle_control_tb_top.sv
`timescale 1ns/1ps
module fan_pwm_throttle_control_tb_top;
	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] wd;
		logic [7:0] ex;
	} fpt_row_type;
	logic core_clk_i;
	logic sys_rst_i;
	logic hready;
	logic hwrite;
	logic hresp;
	logic [1:0] htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] temp;
	logic [31:0] base;
	logic [31:0] rd;
	logic [15:0] step;
	logic [7:0] oe;
	logic [7:0] pd;
	logic [7:0] pins;
	logic [7:0] lvl;
	logic [3:0] hot;
	logic c1s, c2s, r1, r2, t1, t2, pwm;
	int miscompares;
	int samples_checked;
	int cyc = 0;
	int cf, c1, c2, k, v;
	fpt_row_type rows [10] = '{'{8'hC3, 8'hA5, 8'hA5},
		'{8'hC4, 8'h5A, 8'h5A}, '{8'hC5, 8'hFF, 8'hFF},
		'{8'hC6, 8'h0F, 8'h0F}, '{8'hC7, 8'h93, 8'h93},
		'{8'hC8, 8'hC0, 8'hC0}, '{8'hC9, 8'h06, 8'h06},
		'{8'hCA, 8'hF0, 8'hF0}, '{8'hD8, 8'h02, 8'h02},
		'{8'h20, 8'hFF, 8'h00}};
	// Aux, force control, cpu1 and cpu2 high cycles per period
	int tv [5][4] = '{'{0, 8'h40, 20, 0}, '{0, 8'h4F, 320, 0},
		'{0, 8'h87, 0, 160}, '{2, 8'h43, 80, 80}, '{0, 0, 0, 0}};

	fpt_fan_throttle #(
		.TICK_CYCLES(4),
		.MS_CYCLES(10),
		.SLOT_CYCLES(2),
		.RAMP_MS(2)
	) DUT (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.hsel_i(1'b1),
		.haddr_i(haddr),
		.htrans_i(htrans),
		.hwrite_i(hwrite),
		.hsize_i(fpt_pkg::HSIZE_WORD),
		.hwdata_i(hwdata),
		.hready_i(hready),
		.hrdata_o(hrdata),
		.hreadyout_o(hready),
		.hresp_o(hresp),
		.table_temp_i(temp),
		.table_base_i(base),
		.table_step_duty_i(step),
		.cpu1_throttle_signal_i(c1s),
		.cpu2_throttle_signal_i(c2s),
		.regulator1_hot_input_i(r1),
		.regulator2_hot_input_i(r2),
		.gpio_pin_i(pins),
		.output_pulldown_o(pd),
		.output_pulldown_oe_o(oe),
		.cpu1_throttle_o(t1),
		.cpu2_throttle_o(t2),
		.fan_pwm_o(pwm)
	);

	fpt_far_side_model far_side (
		.pulldown_oe_i(oe),
		.pin_level_i(lvl),
		.hot_req_i(hot),
		.gpio_pin_o(pins),
		.cpu1_throttle_signal_o(c1s),
		.cpu2_throttle_signal_o(c2s),
		.regulator1_hot_input_o(r1),
		.regulator2_hot_input_o(r2)
	);

	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask : check

	// Address phase held until hready, then data phase until hready
	task automatic bus(input logic wr, input logic [7:0] idx,
			input logic [7:0] wd);
		@(posedge core_clk_i);
		htrans <= 2'h2;
		haddr <= {22'h000000, idx, 2'h0};
		hwrite <= wr;
		do @(posedge core_clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		do @(posedge core_clk_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		bus(1'b1, idx, wd);
	endtask : wr

	task automatic rdc(input logic [7:0] idx, input logic [31:0] m,
			input logic [31:0] ex);
		bus(1'b0, idx, 8'h00);
		check(rd & m, ex);
		check({31'h00000000, hresp}, 32'h00000000);
	endtask : rdc

	task automatic meas(input int len);
		cf = 0;
		c1 = 0;
		c2 = 0;
		repeat (len) begin
			// Sample mid-cycle, clear of the launching edge
			@(negedge core_clk_i);
			cf += int'(pwm === 1'b1);
			c1 += int'(t1 === 1'b1);
			c2 += int'(t2 === 1'b1);
		end
	endtask : meas

	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			conclude();
		end
	end

	initial begin
		sys_rst_i = 1'b1;
		htrans = 2'h0;
		haddr = 32'h00000000;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		temp = 32'h00000000;
		base = 32'h00000000;
		step = 16'h0000;
		lvl = 8'hFF;
		hot = 4'h0;
		miscompares = 0;
		samples_checked = 0;
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		// Interval written while no throttle traffic runs
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wd);
			rdc(rows[i].idx, 32'hFFFFFFFF, rows[i].ex);
		end
		$display("register table done");
		wr(fpt_pkg::IDX_GPO, 8'hA5);
		repeat (3) @(posedge core_clk_i);
		check(oe, 32'h000000A5);
		check(pd, 32'h00000000);
		rdc(fpt_pkg::IDX_STAT, 32'h000000FF, 32'h0000005A);
		$display("pulldown done");
		@(posedge core_clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			v = (i == 4) ? int'(fpt_pkg::RST_MON) : 0;
			rdc(8'(8'hC3 + i), 32'hFFFFFFFF, v);
		end
		check(oe, 32'h00000000);
		$display("reset values done");
		for (int i = 0; i < 5; i++) begin
			wr(fpt_pkg::IDX_AUX, 8'(tv[i][0]));
			wr(fpt_pkg::IDX_FORCE, 8'(tv[i][1]));
			repeat (330) @(posedge core_clk_i);
			meas(320);
			check(c1, tv[i][2]);
			check(c2, tv[i][3]);
		end
		wr(fpt_pkg::IDX_FORCE, 8'h10);
		@(posedge core_clk_i);
		hot <= 4'h4;
		repeat (20) @(posedge core_clk_i);
		meas(320);
		check(c1, 0);
		wr(fpt_pkg::IDX_FORCE, 8'h00);
		repeat (20) @(posedge core_clk_i);
		meas(320);
		check(c1, 320);
		hot <= 4'h0;
		$display("throttle done");
		for (int i = 0; i < 6; i++) begin
			k = (i < 2) ? 0 : (i < 4) ? 5 : 15;
			v = i % 2;
			wr(fpt_pkg::IDX_CTL, 8'(k * 16 + v * 2 + 1));
			repeat (35) @(posedge core_clk_i);
			meas(30);
			check(cf, v ? 30 - 2 * k : 2 * k);
			rdc(fpt_pkg::IDX_CTL, 32'hFF, k * 16 + v * 2 + 1);
		end
		$display("override done");
		wr(fpt_pkg::IDX_CTL, 8'h00);
		wr(fpt_pkg::IDX_BIND, 8'h01);
		wr(fpt_pkg::IDX_T12, 8'h54);
		@(posedge core_clk_i);
		base <= 32'h00000014;
		temp <= 32'h0000000A;
		step <= 16'h0009;
		repeat (4) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_CTL, 32'hF0, 32'h50);
		temp <= 32'h00000018;
		repeat (4) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_CTL, 32'hF0, 32'h50);
		temp <= 32'h0000001C;
		repeat (4) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_CTL, 32'hF0, 32'h90);
		wr(fpt_pkg::IDX_CTL, 8'h31);
		repeat (4) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_CTL, 32'hFF, 32'h91);
		// Table three with half-degree hysteresis of four steps
		wr(fpt_pkg::IDX_T34, 8'h64);
		wr(fpt_pkg::IDX_AUX, 8'h01);
		wr(fpt_pkg::IDX_BIND, 8'h04);
		@(posedge core_clk_i);
		base <= 32'h00140000;
		temp <= 32'h000A0000;
		step <= 16'h0900;
		repeat (4) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_CTL, 32'hF0, 32'h60);
		temp <= 32'h00180000;
		repeat (4) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_CTL, 32'hF0, 32'h90);
		wr(fpt_pkg::IDX_CTL, 8'h00);
		wr(fpt_pkg::IDX_BIND, 8'h10);
		wr(fpt_pkg::IDX_CTL, 8'h04);
		@(posedge core_clk_i);
		hot <= 4'h1;
		repeat (5) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_CTL, 32'hFF, 32'hFC);
		hot <= 4'h0;
		repeat (400) @(posedge core_clk_i);
		meas(30);
		check(cf, 30);
		// Software clears the lock by writing zero to its bit
		wr(fpt_pkg::IDX_CTL, 8'h04);
		rdc(fpt_pkg::IDX_CTL, 32'h0F, 32'h04);
		wr(fpt_pkg::IDX_CTL, 8'h00);
		@(posedge core_clk_i);
		hot <= 4'h1;
		repeat (5) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_CTL, 32'h0F, 32'h00);
		hot <= 4'h0;
		wr(fpt_pkg::IDX_BIND, 8'h00);
		repeat (400) @(posedge core_clk_i);
		$display("table and lock done");
		wr(fpt_pkg::IDX_BIND, 8'h40);
		@(posedge core_clk_i);
		hot <= 4'h4;
		repeat (400) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_CTL, 32'hF0, 32'hF0);
		hot <= 4'h0;
		repeat (400) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_CTL, 32'hF0, 32'h00);
		wr(fpt_pkg::IDX_BIND, 8'h00);
		$display("ramp done");
		wr(fpt_pkg::IDX_SPIN, 8'h2A);
		rdc(fpt_pkg::IDX_CTL, 32'hFF, 32'h00);
		wr(fpt_pkg::IDX_CTL, 8'h31);
		repeat (40) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_CTL, 32'hFF, 32'h01);
		meas(30);
		check(cf, 20);
		rdc(fpt_pkg::IDX_STAT, 32'h400, 32'h400);
		repeat (1000) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_CTL, 32'hFF, 32'h31);
		meas(30);
		check(cf, 6);
		$display("spin-up done");
		@(posedge core_clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		// Shortest interval set before any throttle activity
		wr(fpt_pkg::IDX_MON, 8'h00);
		repeat (20) @(posedge core_clk_i);
		hot <= 4'h1;
		repeat (100) @(posedge core_clk_i);
		hot <= 4'h0;
		repeat (7400) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_STAT, 32'h300, 32'h100);
		repeat (7400) @(posedge core_clk_i);
		rdc(fpt_pkg::IDX_STAT, 32'h300, 32'h000);
		$display("monitor interval done");
		conclude();
	end
endmodule : fan_pwm_throttle_control_tb_top
